// ---- hw/one_shot_pkg.sv ----
// Package: register map, field layout and types of the one-shot timer channel
package one_shot_pkg;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned CEN_W = 8;
    localparam int unsigned SEL_W = 3;

    // Byte offsets of the registers
    localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
    localparam logic [ADDR_W-1:0] COUNTER_OFS = 5'h04;
    localparam logic [ADDR_W-1:0] PERIOD_OFS = 5'h08;
    localparam logic [ADDR_W-1:0] DUTY_OFS = 5'h0C;
    localparam logic [ADDR_W-1:0] IRQ_FLAG_OFS = 5'h10;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 5'h14;
    localparam logic [ADDR_W-1:0] STATE_OFS = 5'h18;

    // Control field positions
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_ONE_SHOT_BIT = 1;
    localparam int unsigned CTRL_TRIG_BIT = 2;
    localparam int unsigned CTRL_UD_LSB = 3;
    localparam int unsigned CTRL_MODE_LSB = 5;
    localparam int unsigned CTRL_LEVEL_BIT = 7;
    localparam int unsigned CTRL_CSEL_LSB = 8;
    localparam int unsigned CTRL_RST_BIT = 11;

    localparam logic [1:0] UD_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE_PWM = 2'h2;

    // Interrupt flag positions
    localparam int unsigned IRQ_FIRST_BIT = 0;
    localparam int unsigned IRQ_SECOND_BIT = 1;
    localparam int unsigned IRQ_W = 2;

    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_INITIAL = 3'b010,
        ST_PULSE   = 3'b100
    } phase_t;

    typedef struct packed {
        logic [SEL_W-1:0] clk_sel;
        logic             active_level;
        logic [1:0]       pulse_mode;
        logic [1:0]       updown_count_select;
        logic             one_shot_trigger_source;
        logic             one_shot_select;
        logic             enable;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '0;
endpackage

// ---- hw/timer_channel_one_shot_pulse.sv ----
// One timer output channel in one-shot pulse mode with Avalon-MM registers
`timescale 1ns/1ns
module timer_channel_one_shot_pulse (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             sys_rst_i,
    // Avalon-MM slave
    input  wire logic [one_shot_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                             avs_read_i,
    input  wire logic                             avs_write_i,
    input  wire logic [one_shot_pkg::DATA_W-1:0]  avs_writedata_i,
    input  wire logic [3:0]                       avs_byteenable_i,
    output logic      [one_shot_pkg::DATA_W-1:0]  avs_readdata_o,
    output logic                                  avs_waitrequest_o,
    // Clock enables and start triggers
    input  wire logic [one_shot_pkg::CEN_W-1:0]   clk_en_i,
    input  wire logic                             chain_trigger_in_i,
    input  wire logic                             external_capture_trigger_i,
    // Channel outputs
    output logic                                  pwm_o,
    output logic                                  first_compare_trigger_o,
    output logic                                  second_compare_trigger_o,
    output logic                                  irq_o
);
    import one_shot_pkg::*;

    ctrl_t             ctrl_reg, ctrl_next;
    phase_t            phase_reg, phase_next;
    logic [CNT_W-1:0]  channel_counter_reg, channel_counter_next;
    logic [CNT_W-1:0]  period_compare_reg, period_compare_next;
    logic [CNT_W-1:0]  duty_compare_reg, duty_compare_next;
    logic [IRQ_W-1:0]  channel_irq_flag_reg, channel_irq_flag_next;
    logic [IRQ_W-1:0]  irq_en_reg, irq_en_next;
    logic              active_reg, active_next;
    logic              pwm_reg, pwm_next;
    logic              trig0_reg, trig0_next;
    logic              trig1_reg, trig1_next;
    logic              ack_reg, ack_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;

    logic              bus_req;
    logic              wr_take;
    logic              cen;
    logic              sw_launch;
    logic              hw_launch;
    logic              hit0;
    logic              hit1;
    logic              counting;
    logic [IRQ_W-1:0]  events;

    // Counter sits on the cycle before the compare value
    function automatic logic at_minus_one(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp);
        at_minus_one = (cnt == cmp - CNT_ONE);
    endfunction

    // Write mask from the byte enables
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v, input logic [DATA_W-1:0] new_v,
                                                input logic [3:0] be);
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    // One wait state: waitrequest drops in the second cycle of each request
    assign bus_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_reg;
    assign wr_take = avs_write_i & ack_reg;

    assign cen = clk_en_i[ctrl_reg.clk_sel];
    assign counting = (phase_reg != ST_IDLE) && ctrl_reg.enable;
    assign hit0 = counting && cen && at_minus_one(channel_counter_reg, period_compare_reg);
    assign hit1 = counting && cen && at_minus_one(channel_counter_reg, duty_compare_reg);
    assign events = {hit1, hit0};

    // Launch conditions; the compare path has no history, so repeated shots behave alike
    assign sw_launch = wr_take && (avs_address_i == COUNTER_OFS) && ctrl_reg.enable
                       && ctrl_reg.one_shot_select && !ctrl_reg.one_shot_trigger_source
                       && (ctrl_reg.updown_count_select == UD_OFF)
                       && (ctrl_reg.pulse_mode == MODE_SINGLE_PWM);
    assign hw_launch = ctrl_reg.enable && ctrl_reg.one_shot_select && ctrl_reg.one_shot_trigger_source
                       && (chain_trigger_in_i | external_capture_trigger_i);

    // Register bus: read data is latched in the wait cycle and stands when waitrequest drops
    always_comb begin
        ack_next = bus_req & ~ack_reg;
        rdata_next = rdata_reg;

        // Reads have no side effects, so holding the latched word is safe
        if (avs_read_i && !ack_reg) begin
            unique case (avs_address_i)
                CTRL_OFS:     rdata_next = {{(DATA_W-CTRL_RST_BIT){1'b0}}, ctrl_reg};
                COUNTER_OFS:  rdata_next = {{(DATA_W-CNT_W){1'b0}}, channel_counter_reg};
                PERIOD_OFS:   rdata_next = {{(DATA_W-CNT_W){1'b0}}, period_compare_reg};
                DUTY_OFS:     rdata_next = {{(DATA_W-CNT_W){1'b0}}, duty_compare_reg};
                IRQ_FLAG_OFS: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, channel_irq_flag_reg};
                IRQ_EN_OFS:   rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_en_reg};
                STATE_OFS:    rdata_next = {{(DATA_W-4){1'b0}}, pwm_reg, phase_reg};
                default:      rdata_next = DATA_ZERO;
            endcase
        end
    end

    // Configuration registers
    always_comb begin
        logic [DATA_W-1:0] cv;
        cv = DATA_ZERO;
        ctrl_next = ctrl_reg;
        period_compare_next = period_compare_reg;
        duty_compare_next = duty_compare_reg;
        irq_en_next = irq_en_reg;

        // Channel reset bit is not stored: it acts on the engine only
        if (wr_take) begin
            unique case (avs_address_i)
                CTRL_OFS: begin
                    cv = merge({{(DATA_W-CTRL_RST_BIT){1'b0}}, ctrl_reg}, avs_writedata_i, avs_byteenable_i);
                    ctrl_next = ctrl_t'(cv[CTRL_RST_BIT-1:0]);
                end
                PERIOD_OFS: begin
                    cv = merge({{(DATA_W-CNT_W){1'b0}}, period_compare_reg}, avs_writedata_i, avs_byteenable_i);
                    period_compare_next = cv[CNT_W-1:0];
                end
                DUTY_OFS: begin
                    cv = merge({{(DATA_W-CNT_W){1'b0}}, duty_compare_reg}, avs_writedata_i, avs_byteenable_i);
                    duty_compare_next = cv[CNT_W-1:0];
                end
                IRQ_EN_OFS: begin
                    cv = merge({{(DATA_W-IRQ_W){1'b0}}, irq_en_reg}, avs_writedata_i, avs_byteenable_i);
                    irq_en_next = cv[IRQ_W-1:0];
                end
                default: begin
                    cv = DATA_ZERO;
                end
            endcase
        end
    end

    // Counting engine and shot control
    always_comb begin
        logic [DATA_W-1:0] wv;
        wv = DATA_ZERO;
        phase_next = phase_reg;
        channel_counter_next = channel_counter_reg;
        active_next = active_reg;
        trig0_next = hit0;
        trig1_next = hit1;

        // Counting engine
        if (counting && cen) begin
            unique case (phase_reg)
                ST_INITIAL: begin
                    if (hit0) begin
                        active_next = 1'b1;
                        channel_counter_next = CNT_RST;
                        phase_next = ST_PULSE;
                    end else begin
                        channel_counter_next = channel_counter_reg + CNT_ONE;
                    end
                end
                ST_PULSE: begin
                    if (hit1) begin
                        active_next = 1'b0;
                    end
                    if (hit0) begin
                        // Shot is over after one period of the pulse phase
                        active_next = 1'b0;
                        channel_counter_next = CNT_RST;
                        phase_next = ST_IDLE;
                    end else begin
                        channel_counter_next = channel_counter_reg + CNT_ONE;
                    end
                end
                default: begin
                    phase_next = ST_IDLE;
                end
            endcase
        end

        if (hw_launch) begin
            channel_counter_next = CNT_RST;
            active_next = 1'b0;
            phase_next = ST_INITIAL;
        end

        // Register writes win over the engine, a counter write may launch a shot
        if (wr_take) begin
            unique case (avs_address_i)
                CTRL_OFS: begin
                    wv = merge({{(DATA_W-CTRL_RST_BIT){1'b0}}, ctrl_reg}, avs_writedata_i, avs_byteenable_i);
                    if (wv[CTRL_RST_BIT] || !wv[CTRL_ENABLE_BIT]) begin
                        // Channel reset or disable stops any shot in progress
                        phase_next = ST_IDLE;
                        active_next = 1'b0;
                    end
                    if (wv[CTRL_RST_BIT]) begin
                        channel_counter_next = CNT_RST;
                    end
                end
                COUNTER_OFS: begin
                    wv = merge({{(DATA_W-CNT_W){1'b0}}, channel_counter_reg}, avs_writedata_i, avs_byteenable_i);
                    channel_counter_next = wv[CNT_W-1:0];
                    if (sw_launch) begin
                        active_next = 1'b0;
                        phase_next = ST_INITIAL;
                    end
                end
                default: begin
                    wv = DATA_ZERO;
                end
            endcase
        end

        // Output level follows the new control word so a level change shows at once
        pwm_next = active_next ? ctrl_next.active_level : ~ctrl_next.active_level;
    end

    // Sticky flags: write one to clear, a new event in the same cycle wins
    always_comb begin
        channel_irq_flag_next = channel_irq_flag_reg;
        if (wr_take && (avs_address_i == IRQ_FLAG_OFS) && avs_byteenable_i[0]) begin
            channel_irq_flag_next = channel_irq_flag_reg & ~avs_writedata_i[IRQ_W-1:0];
        end
        channel_irq_flag_next = channel_irq_flag_next | (events & irq_en_reg);
    end

    // Bus handshake registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= DATA_ZERO;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RST;
            period_compare_reg <= CNT_RST;
            duty_compare_reg <= CNT_RST;
            irq_en_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            period_compare_reg <= period_compare_next;
            duty_compare_reg <= duty_compare_next;
            irq_en_reg <= irq_en_next;
        end
    end

    // Engine registers; output resets to the inactive level of a zero control word
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_reg <= ST_IDLE;
            channel_counter_reg <= CNT_RST;
            active_reg <= 1'b0;
            pwm_reg <= 1'b1;
            trig0_reg <= 1'b0;
            trig1_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            channel_counter_reg <= channel_counter_next;
            active_reg <= active_next;
            pwm_reg <= pwm_next;
            trig0_reg <= trig0_next;
            trig1_reg <= trig1_next;
        end
    end

    // Notify flags
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            channel_irq_flag_reg <= '0;
        end else begin
            channel_irq_flag_reg <= channel_irq_flag_next;
        end
    end

    assign avs_readdata_o = rdata_reg;
    assign pwm_o = pwm_reg;
    assign first_compare_trigger_o = trig0_reg;
    assign second_compare_trigger_o = trig1_reg;
    assign irq_o = |(channel_irq_flag_reg & irq_en_reg);
endmodule // timer_channel_one_shot_pulse

// ---- sim/timer_channel_one_shot_pulse_chk.sv ----
// Checker of bus handshake, trigger and output timing of the one-shot channel
`timescale 1ns/1ns
module timer_channel_one_shot_pulse_chk (
    // Clock and reset
    input wire logic                            clk_i,
    input wire logic                            sys_rst_i,
    // Bus
    input wire logic                            avs_read_i,
    input wire logic                            avs_write_i,
    input wire logic [one_shot_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic                            avs_waitrequest_o,
    // Enables and triggers
    input wire logic [one_shot_pkg::CEN_W-1:0]  clk_en_i,
    input wire logic                            chain_trigger_in_i,
    input wire logic                            external_capture_trigger_i,
    // Outputs
    input wire logic                            pwm_o,
    input wire logic                            first_compare_trigger_o,
    input wire logic                            second_compare_trigger_o,
    input wire logic                            irq_o
);
    import one_shot_pkg::*;
    logic req;
    logic wr_done;
    logic hw_start;
    logic trig_any;
    assign req = avs_read_i | avs_write_i;
    assign wr_done = avs_write_i & ~avs_waitrequest_o;
    assign hw_start = chain_trigger_in_i | external_capture_trigger_i;
    assign trig_any = first_compare_trigger_o | second_compare_trigger_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_wait_first_cycle: assert property ($rose(req) |-> avs_waitrequest_o) else $error("no wait state");
    a_wait_one_state: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait too long");
    a_idle_no_wait: assert property (!req |-> !avs_waitrequest_o) else $error("wait while idle");
    a_read_data_hold: assert property (!$past(avs_read_i && avs_waitrequest_o) |-> $stable(avs_readdata_o))
        else $error("read data moved");
    a_first_needs_cen: assert property (first_compare_trigger_o |-> $past(|clk_en_i))
        else $error("first trigger without enable");
    a_second_needs_cen: assert property (second_compare_trigger_o |-> $past(|clk_en_i))
        else $error("second trigger without enable");
    // Output edges come only from a compare, a register write or a start trigger
    a_pwm_has_cause: assert property ($changed(pwm_o) |-> trig_any || $past(wr_done) || $past(wr_done, 2)
        || $past(hw_start) || $past(hw_start, 2)) else $error("output edge without cause");
    a_irq_has_cause: assert property ($rose(irq_o) |-> trig_any || $past(trig_any) || $past(wr_done)
        || $past(wr_done, 2)) else $error("interrupt without cause");

    c_write: cover property (wr_done);
    c_pulse: cover property ($fell(pwm_o));
    c_second_initial: cover property (second_compare_trigger_o && pwm_o);
    c_irq: cover property ($rose(irq_o));
endmodule // timer_channel_one_shot_pulse_chk

bind timer_channel_one_shot_pulse timer_channel_one_shot_pulse_chk u_chk (.clk_i, .sys_rst_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .clk_en_i, .chain_trigger_in_i, .external_capture_trigger_i,
    .pwm_o, .first_compare_trigger_o, .second_compare_trigger_o, .irq_o);

// ---- sim/timer_channel_one_shot_pulse_bench.sv ----
// Self-checking bench of the one-shot timer channel
`timescale 1ns/1ns
module timer_channel_one_shot_pulse_bench;
    import one_shot_pkg::*;
    logic              clk, rst, read, write, waitreq, chain, capture, pwm, trig0, trig1, irq;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata, readdata, got;
    logic [CEN_W-1:0]  clk_en;
    int                failures, checked, cycles;

    timer_channel_one_shot_pulse dut (.clk_i(clk), .sys_rst_i(rst), .avs_address_i(address), .avs_read_i(read),
        .avs_write_i(write), .avs_writedata_i(writedata), .avs_byteenable_i(4'hF), .avs_readdata_o(readdata),
        .avs_waitrequest_o(waitreq), .clk_en_i(clk_en), .chain_trigger_in_i(chain),
        .external_capture_trigger_i(capture), .pwm_o(pwm), .first_compare_trigger_o(trig0),
        .second_compare_trigger_o(trig1), .irq_o(irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Bit 1 runs at half rate to show counting only on the selected enable
    always @(posedge clk) clk_en <= {6'h3F, ~clk_en[1], 1'b1};
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Returns just after the accepting edge; next call waits an edge first
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= ~w;
        do @(posedge clk); while (waitreq !== 1'b0);
        got = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    // Kind 0 launches by counter write, 1 by chain, 2 by capture; counts selected enables
    task automatic shot(input int kind, input logic [15:0] start, input int sel, input int t1_exp);
        int n;
        int t1n;
        logic en;
        if (kind == 0) bus(1'b1, COUNTER_OFS, {16'h0000, start});
        else begin
            @(posedge clk);
            chain <= (kind == 1);
            capture <= (kind == 2);
            @(posedge clk);
            chain <= 1'b0;
            capture <= 1'b0;
        end
        #1;
        n = 0;
        t1n = 0;
        do begin
            en = clk_en[sel];
            @(posedge clk);
            #1;
            n += int'(en);
            t1n += int'(trig1 === 1'b1 && pwm === 1'b1);
        end while (pwm !== 1'b0 && n < 64);
        chk(32'(n), 32'(4 - int'(start)));
        chk(32'(trig0), 32'h1);
        chk(32'(t1n), 32'(t1_exp));
        n = 0;
        do begin
            en = clk_en[sel];
            @(posedge clk);
            #1;
            n += int'(en);
        end while (pwm === 1'b0 && n < 64);
        chk(32'(n), 32'h2);
        chk(32'(trig1), 32'h1);
        repeat (16) @(posedge clk);
        bus(1'b0, STATE_OFS, DATA_ZERO);
        chk(got, 32'h9);
    endtask

    task automatic t_reset;
        bus(1'b0, CTRL_OFS, DATA_ZERO);
        chk(got, DATA_ZERO);
        bus(1'b0, STATE_OFS, DATA_ZERO);
        chk(got, 32'h9);
        bus(1'b0, 5'h1C, DATA_ZERO);
        chk(got, DATA_ZERO);
        $display("test reset done");
    endtask
    task automatic t_shots;
        bus(1'b1, PERIOD_OFS, 32'h4);
        bus(1'b1, DUTY_OFS, 32'h2);
        bus(1'b1, IRQ_EN_OFS, 32'h3);
        bus(1'b1, CTRL_OFS, 32'h43);
        shot(0, 16'h1, 0, 1);
        shot(0, 16'h1, 0, 1);
        shot(0, 16'h3, 0, 0);
        bus(1'b1, COUNTER_OFS, DATA_ZERO);
        shot(0, 16'h1, 0, 1);
        $display("test software shots done");
    endtask
    task automatic t_irq;
        bus(1'b0, IRQ_FLAG_OFS, DATA_ZERO);
        chk(got, 32'h3);
        chk(32'(irq), 32'h1);
        bus(1'b1, IRQ_FLAG_OFS, 32'h1);
        bus(1'b0, IRQ_FLAG_OFS, DATA_ZERO);
        chk(got, 32'h2);
        bus(1'b1, IRQ_EN_OFS, DATA_ZERO);
        #1;
        chk(32'(irq), 32'h0);
        bus(1'b1, IRQ_FLAG_OFS, 32'h2);
        bus(1'b0, IRQ_FLAG_OFS, DATA_ZERO);
        chk(got, DATA_ZERO);
        $display("test interrupt done");
    endtask
    task automatic t_slow_hw;
        bus(1'b1, CTRL_OFS, 32'h143);
        shot(0, 16'h1, 1, 1);
        bus(1'b1, CTRL_OFS, 32'h47);
        shot(1, 16'h0, 0, 1);
        shot(2, 16'h0, 0, 1);
        bus(1'b0, IRQ_FLAG_OFS, DATA_ZERO);
        chk(got, DATA_ZERO);
        $display("test slow enable and hardware start done");
    endtask
    task automatic t_refused;
        logic [DATA_W-1:0] bad [4] = '{32'h23, 32'h4B, 32'h41, 32'h47};
        foreach (bad[i]) begin
            bus(1'b1, CTRL_OFS, bad[i]);
            bus(1'b1, COUNTER_OFS, 32'h1);
            repeat (12) @(posedge clk);
            bus(1'b0, STATE_OFS, DATA_ZERO);
            chk(got, 32'h9);
        end
        bus(1'b1, CTRL_OFS, 32'h43);
        bus(1'b1, COUNTER_OFS, 32'h1);
        bus(1'b1, CTRL_OFS, 32'h843);
        bus(1'b0, STATE_OFS, DATA_ZERO);
        chk(got, 32'h9);
        bus(1'b0, COUNTER_OFS, DATA_ZERO);
        chk(got, DATA_ZERO);
        $display("test refused launches and channel reset done");
    endtask

    initial begin
        {rst, read, write, chain, capture, address, writedata} = '0;
        rst = 1'b1;
        clk_en = 8'hFF;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_shots();
        t_irq();
        t_slow_hw();
        t_refused();
        end_of_test();
    end
endmodule // timer_channel_one_shot_pulse_bench
